// [verilog/speed_ref_pkg.sv]
/*
  Shared settings for the speed reference selector: setting selectors,
  codes, field layout and factory defaults.
  Assumes a single clock domain; timing counts derive from CLOCK_HZ.
*/
`default_nettype none
package speed_ref_pkg;
  // ----------------------------------------------------------------
  // Clock and sampling
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20_000_000;
  localparam int SAMPLE_PERIOD_US = 2000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * (CLOCK_HZ / 1_000_000);
  localparam int SPEED_W = 16;
  localparam int PRESET_N = 4;

  // ----------------------------------------------------------------
  // Setting selectors on the configuration port
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_REF_SOURCE = 4'h5;
  localparam logic [3:0] SEL_RUN_TYPE = 4'h2;
  localparam logic [3:0] SEL_AI1_MODE = 4'h6;
  localparam logic [3:0] SEL_AI3_MODE = 4'h8;
  localparam logic [3:0] SEL_HI_ROUTE = 4'h4;
  localparam logic [3:0] SEL_MENU6_3WIRE = 4'h3;
  localparam logic [3:0] SEL_RESTORE = 4'h1;
  localparam logic [3:0] SEL_PRESET_BASE = 4'hA;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FACTORY = 3'h0;
  localparam logic [2:0] SRC_ANALOG1 = 3'h1;
  localparam logic [2:0] SRC_ANALOG2 = 3'h2;
  localparam logic [2:0] SRC_PRESET = 3'h4;
  localparam logic [1:0] RUN_PLAIN = 2'h0;
  localparam logic [1:0] RUN_JOG_3WIRE = 2'h1;
  localparam logic [1:0] RUN_REVERSE = 2'h2;
  localparam logic [2:0] AI_MODE_VOLT = 3'h0;
  localparam logic [2:0] AI_MODE_CUR_NO_TRIP = 3'h4;
  localparam logic [2:0] AI_MODE_PTC = 3'h7;
  localparam logic [15:0] RESTORE_HIGH = 16'h0001;
  localparam logic [15:0] RESTORE_LOW = 16'h0003;

  typedef enum logic [1:0] {REF_VOLTAGE, REF_CURRENT, REF_PRESET} ref_kind_type;

  typedef struct packed {
    logic wr;
    logic [3:0] sel;
    logic [15:0] data;
  } cfg_req_type;

  typedef struct packed {
    logic [2:0] ref_src;
    logic [1:0] run_type;
    logic [2:0] ai1_mode;
    logic [2:0] ai3_mode;
    logic hi_route;
    logic menu6_3wire;
    logic [PRESET_N-1:0][SPEED_W-1:0] preset;
  } cfg_type;

  localparam cfg_type CFG_DEFAULT = '{
    ref_src: SRC_FACTORY, run_type: RUN_PLAIN, ai1_mode: AI_MODE_VOLT,
    ai3_mode: AI_MODE_VOLT, hi_route: 1'b1, menu6_3wire: 1'b0,
    preset: '0};
endpackage
`default_nettype wire

// [verilog/speed_reference_selector.sv]
/*
  Speed reference selector and run gating for a drive control terminal.
  Assumes terminal inputs are already synchronous to clock and that the
  controlling party holds unlock open while it writes settings.
*/
`default_nettype none
`timescale 1ns/10ps
// What this block does
// - Run acts only with unlock input closed
// - Settings writable only while unlock is open
// - Restore codes 1 or 3 reload defaults
// - Run type picks plain, jog or reverse
// - Three-wire jog needs the separate enable
// - Factory map: voltage, preset 2, current, preset 2
// - Source 1: voltage then presets 2-4
// - Source 2: first analog input (current kind only in current mode), then presets 2-4
// - Source 4: presets 1 to 4
// - Each preset is its own speed setting
// - High select bit routed only when enabled
// - Third analog mode may choose PTC probe
module speed_reference_selector
  import speed_ref_pkg::*;
#(
  parameter int SAMPLE_TICKS = SAMPLE_CYCLES
) (
  input wire logic clock, // 20 MHz
  input wire logic sys_rst, // Async, active high
  input wire logic secure_unlock_input, // High = closed
  input wire logic ref_select_bit_low, // First select terminal
  input wire logic ref_select_bit_high, // Second select terminal
  input wire logic [SPEED_W-1:0] first_analog_input, // Converted sample
  input wire logic [SPEED_W-1:0] second_analog_input, // Converted sample
  input wire logic run_cmd, // Run level or run push
  input wire logic stop_n, // Three-wire stop, low = stop
  input wire logic reverse_cmd, // Reverse direction request
  input wire cfg_req_type cfg_req, // Setting write, wr is a pulse
  output ref_kind_type ref_kind_r, // Active reference kind
  output logic [SPEED_W-1:0] ref_value_r, // Active reference value
  output logic run_r, // Drive running
  output logic reverse_r, // Reverse direction
  output logic cfg_refused_r, // Write refused pulse
  output logic ai1_current_r, // First analog in current mode
  output logic ptc_mode_r // Third analog monitors PTC
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SAMPLE_TICKS < 2) begin : g_bad_ticks
    $error("SAMPLE_TICKS must be at least 2");
  end

  cfg_type cfg_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [1:0] pair_r;
  logic restore_hit;
  logic [1:0] preset_idx;
  ref_kind_type kind_nxt;
  logic [SPEED_W-1:0] value_nxt;

  assign restore_hit = cfg_req.data == RESTORE_HIGH ||
                       cfg_req.data == RESTORE_LOW;
  // Offset from the first preset selector, so preset 1 lands in slot 0
  assign preset_idx = 2'(cfg_req.sel - SEL_PRESET_BASE);

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= CFG_DEFAULT;
      cfg_refused_r <= 1'b0;
    end else begin
      cfg_refused_r <= cfg_req.wr & secure_unlock_input;
      if (cfg_req.wr && !secure_unlock_input) begin
        case (cfg_req.sel)
          SEL_RESTORE: begin
            if (restore_hit) begin
              cfg_r <= CFG_DEFAULT;
            end
          end
          SEL_REF_SOURCE: cfg_r.ref_src <= cfg_req.data[2:0];
          SEL_RUN_TYPE: cfg_r.run_type <= cfg_req.data[1:0];
          SEL_AI1_MODE: cfg_r.ai1_mode <= cfg_req.data[2:0];
          SEL_AI3_MODE: cfg_r.ai3_mode <= cfg_req.data[2:0];
          SEL_HI_ROUTE: cfg_r.hi_route <= cfg_req.data[0];
          SEL_MENU6_3WIRE: cfg_r.menu6_3wire <= cfg_req.data[0];
          SEL_PRESET_BASE, SEL_PRESET_BASE + 4'h1,
          SEL_PRESET_BASE + 4'h2, SEL_PRESET_BASE + 4'h3: begin
            cfg_r.preset[preset_idx] <= cfg_req.data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Select sampling
  // ----------------------------------------------------------------
  // Both bits latch on the same edge so a skewed change never shows
  // a pair that was not present on the terminals.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
      pair_r <= 2'h0;
    end else begin
      tick_r <= tick_cnt_r == 32'(SAMPLE_TICKS - 1);
      if (tick_cnt_r == 32'(SAMPLE_TICKS - 1)) begin
        tick_cnt_r <= 32'h00000000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
      if (tick_r) begin
        pair_r <= {ref_select_bit_high & cfg_r.hi_route,
                   ref_select_bit_low};
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference choice
  // ----------------------------------------------------------------
  always_comb begin
    kind_nxt = REF_PRESET;
    value_nxt = cfg_r.preset[pair_r];
    case (cfg_r.ref_src)
      SRC_FACTORY: begin
        if (pair_r[0]) begin
          value_nxt = cfg_r.preset[1];
        end else if (pair_r[1]) begin
          kind_nxt = REF_CURRENT;
          value_nxt = second_analog_input;
        end else begin
          kind_nxt = REF_VOLTAGE;
          value_nxt = first_analog_input;
        end
      end
      SRC_ANALOG2: begin
        if (pair_r == 2'h0) begin
          kind_nxt = cfg_r.ai1_mode == AI_MODE_CUR_NO_TRIP ?
                     REF_CURRENT : REF_VOLTAGE;
          value_nxt = first_analog_input;
        end
      end
      SRC_PRESET: begin
      end
      default: begin
        // Unlisted codes behave as analog input 1
        if (pair_r == 2'h0) begin
          kind_nxt = REF_VOLTAGE;
          value_nxt = first_analog_input;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_kind_r <= REF_VOLTAGE;
      ref_value_r <= 16'h0000;
      ai1_current_r <= 1'b0;
      ptc_mode_r <= 1'b0;
    end else begin
      ref_kind_r <= kind_nxt;
      ref_value_r <= value_nxt;
      ai1_current_r <= cfg_r.ai1_mode == AI_MODE_CUR_NO_TRIP;
      ptc_mode_r <= cfg_r.ai3_mode == AI_MODE_PTC;
    end
  end

  // ----------------------------------------------------------------
  // Run gating
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      reverse_r <= 1'b0;
    end else if (!secure_unlock_input) begin
      run_r <= 1'b0;
      reverse_r <= 1'b0;
    end else begin
      case (cfg_r.run_type)
        RUN_PLAIN: begin
          run_r <= run_cmd;
          reverse_r <= 1'b0;
        end
        RUN_JOG_3WIRE: begin
          reverse_r <= 1'b0;
          // Stop wins over a held run push
          if (!cfg_r.menu6_3wire || !stop_n) begin
            run_r <= 1'b0;
          end else if (run_cmd) begin
            run_r <= 1'b1;
          end
        end
        RUN_REVERSE: begin
          run_r <= run_cmd;
          reverse_r <= run_cmd & reverse_cmd;
        end
        default: begin
          run_r <= 1'b0;
          reverse_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_run_needs_unlock: assert property ($rose(run_r) |->
    $past(secure_unlock_input)) else $error("run without unlock");
  a_run_drops_lock: assert property (!secure_unlock_input |=> !run_r)
    else $error("run held with unlock open");
  a_cfg_locked: assert property (cfg_req.wr && secure_unlock_input |=>
    $stable(cfg_r) && cfg_refused_r) else $error("write not refused");
  a_restore_load: assert property (cfg_req.wr && !secure_unlock_input &&
    cfg_req.sel == SEL_RESTORE && restore_hit |=> cfg_r == CFG_DEFAULT)
    else $error("restore missed");
  a_reverse_type: assert property (reverse_r |->
    $past(cfg_r.run_type) == RUN_REVERSE) else $error("bad reverse");
  a_jog_disabled: assert property (cfg_r.run_type == RUN_JOG_3WIRE &&
    !cfg_r.menu6_3wire |=> !run_r) else $error("3-wire ran");
  a_factory_map: assert property (cfg_r.ref_src == SRC_FACTORY &&
    pair_r == 2'h2 |=> ref_kind_r == REF_CURRENT)
    else $error("factory current map");
  a_src1_map: assert property (cfg_r.ref_src == SRC_ANALOG1 &&
    pair_r == 2'h2 |=> ref_value_r == $past(cfg_r.preset[2]))
    else $error("source 1 preset 3");
  a_src2_map: assert property (cfg_r.ref_src == SRC_ANALOG2 &&
    pair_r == 2'h0 |=> ref_value_r == $past(first_analog_input))
    else $error("source 2 analog");
  a_src4_map: assert property (cfg_r.ref_src == SRC_PRESET |=>
    ref_kind_r == REF_PRESET && ref_value_r == $past(cfg_r.preset[pair_r]))
    else $error("source 4 preset");
  a_hi_route_off: assert property (!cfg_r.hi_route && tick_r |=>
    !pair_r[1]) else $error("high bit leaked");
  a_ptc_mode: assert property (ptc_mode_r ==
    ($past(cfg_r.ai3_mode) == AI_MODE_PTC)) else $error("ptc mode");
  a_pair_on_tick: assert property (!$stable(pair_r) |->
    $past(tick_r)) else $error("pair moved off tick");

  c_reverse_run: cover property (run_r && reverse_r);
  c_jog_latch: cover property (run_r && !run_cmd);
  c_preset4: cover property (ref_kind_r == REF_PRESET && pair_r == 2'h3);
  c_restore: cover property (cfg_req.wr && cfg_req.sel == SEL_RESTORE);
endmodule // speed_reference_selector
`default_nettype wire

// [verification/terminal_panel.sv]
/*
  Model of the operator switches or controller on the control terminals.
  Assumes the bench raises cfg_mode around every setting change.
*/
`timescale 1ns/10ps
`default_nettype none
module terminal_panel (
  input wire logic clock, // Drive clock
  input wire logic sys_rst, // Async, active high
  input wire logic cfg_mode, // Bench is configuring
  input wire logic want_run, // Bench asks for run
  input wire logic want_stop, // Bench pushes stop
  output logic secure_unlock_input, // High = closed
  output logic run_cmd, // Run terminal
  output logic stop_n // Stop terminal, low = stop
);
  // ----------------------------------------------------------------
  // Switch levels, moved just after a clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      secure_unlock_input <= 1'b0;
      run_cmd <= 1'b0;
      stop_n <= 1'b1;
    end else begin
      secure_unlock_input <= !cfg_mode;
      run_cmd <= want_run;
      stop_n <= !want_stop;
    end
  end
endmodule // terminal_panel
`default_nettype wire

// [verification/speed_reference_selector_test.sv]
/*
  Self-checking bench for the speed reference selector.
  Assumes SAMPLE_TICKS is shortened to 4 so selects settle quickly.
*/
`timescale 1ns/10ps
`default_nettype none
module speed_reference_selector_test;
  import speed_ref_pkg::*;
  logic clock = 0, sys_rst = 1, cfg_mode = 0, want_run = 0, want_stop = 0;
  logic sel_lo = 0, sel_hi = 0, reverse_cmd = 0, unlock, run_cmd, stop_n;
  logic [15:0] a1 = 16'h0000, a2 = 16'h0000;
  logic [15:0] pre [4];
  cfg_req_type cfg_req = '0;
  ref_kind_type ref_kind_r;
  logic [15:0] ref_value_r;
  logic run_r, reverse_r, cfg_refused_r, ai1_current_r, ptc_mode_r;
  int n_fail = 0, check_count = 0;
  logic [31:0] seed = 32'h00000062;
  logic [2:0] srcs [4] = '{SRC_FACTORY, SRC_ANALOG1, SRC_ANALOG2, SRC_PRESET};
  always #25 clock = ~clock;
  terminal_panel panel (.clock(clock), .sys_rst(sys_rst),
    .cfg_mode(cfg_mode), .want_run(want_run), .want_stop(want_stop),
    .secure_unlock_input(unlock), .run_cmd(run_cmd), .stop_n(stop_n));
  speed_reference_selector #(.SAMPLE_TICKS(4)) uut (.clock(clock),
    .sys_rst(sys_rst), .secure_unlock_input(unlock),
    .ref_select_bit_low(sel_lo), .ref_select_bit_high(sel_hi),
    .first_analog_input(a1), .second_analog_input(a2), .run_cmd(run_cmd),
    .stop_n(stop_n), .reverse_cmd(reverse_cmd), .cfg_req(cfg_req),
    .ref_kind_r(ref_kind_r), .ref_value_r(ref_value_r), .run_r(run_r),
    .reverse_r(reverse_r), .cfg_refused_r(cfg_refused_r),
    .ai1_current_r(ai1_current_r), .ptc_mode_r(ptc_mode_r));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [17:0] exp_ref(logic [2:0] s, logic h, logic l,
                                          logic cur);
    logic [1:0] p;
    p = {h, l};
    if (s == SRC_PRESET) return {REF_PRESET, pre[p]};
    if (p == 2'h0) return {(s == SRC_ANALOG2 && cur) ? REF_CURRENT
                           : REF_VOLTAGE, a1};
    if (s == SRC_FACTORY) return (p == 2'h2) ? {REF_CURRENT, a2}
                                            : {REF_PRESET, pre[1]};
    return {REF_PRESET, pre[p]};
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr_cfg(logic [3:0] sel, logic [15:0] data);
    @(posedge clock);
    cfg_req <= '{wr: 1'b1, sel: sel, data: data};
    @(posedge clock);
    cfg_req.wr <= 1'b0;
  endtask
  task automatic mode(logic m);
    @(posedge clock);
    cfg_mode <= m;
    settle(3);
  endtask
  task automatic pick(logic h, logic l);
    @(posedge clock);
    sel_hi <= h;
    sel_lo <= l;
    settle(12);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    n_fail++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    a1 <= 16'(xs());
    a2 <= 16'(xs());
    settle(3);
    chk("factory pair 00", {ref_kind_r, ref_value_r}, {REF_VOLTAGE, a1});
    mode(1);
    for (int i = 0; i < 4; i++) begin
      pre[i] = 16'(xs());
      wr_cfg(SEL_PRESET_BASE + 4'(i), pre[i]);
    end
    wr_cfg(SEL_AI1_MODE, 16'(AI_MODE_CUR_NO_TRIP));
    wr_cfg(SEL_AI3_MODE, 16'(AI_MODE_PTC));
    settle(2);
    chk("ai1 current", ai1_current_r, 1);
    chk("ptc mode", ptc_mode_r, 1);
    foreach (srcs[s]) begin
      wr_cfg(SEL_REF_SOURCE, 16'(srcs[s]));
      for (int p = 0; p < 4; p++) begin
        pick(p[1], p[0]);
        chk("ref map", {ref_kind_r, ref_value_r},
            exp_ref(srcs[s], p[1], p[0], 1'b1));
      end
    end
    wr_cfg(SEL_HI_ROUTE, 16'h0000);
    pick(1, 0);
    chk("high unrouted", ref_value_r, pre[0]);
    wr_cfg(SEL_HI_ROUTE, 16'h0001);
    settle(12);
    chk("high routed", ref_value_r, pre[2]);
    mode(0);
    wr_cfg(SEL_REF_SOURCE, 16'(SRC_ANALOG1));
    @(negedge clock);
    chk("refused pulse", cfg_refused_r, 1);
    settle(12);
    chk("refused kept", ref_value_r, pre[2]);
    for (int t = 0; t < 4; t++) begin
      mode(1);
      wr_cfg(SEL_RUN_TYPE, 16'(t));
      mode(0);
      @(posedge clock);
      want_run <= 1'b1;
      reverse_cmd <= 1'b1;
      settle(3);
      chk("run by type", run_r, t == 0 || t == 2);
      chk("reverse by type", reverse_r, t == 2);
      mode(1);
      chk("run while open", run_r, 0);
      want_run <= 1'b0;
    end
    wr_cfg(SEL_MENU6_3WIRE, 16'h0001);
    wr_cfg(SEL_RUN_TYPE, 16'(RUN_JOG_3WIRE));
    mode(0);
    @(posedge clock);
    want_run <= 1'b1;
    @(posedge clock);
    want_run <= 1'b0;
    settle(4);
    chk("jog latched", run_r, 1);
    want_stop <= 1'b1;
    settle(3);
    chk("jog stopped", run_r, 0);
    want_stop <= 1'b0;
    mode(1);
    wr_cfg(SEL_RESTORE, 16'h0002);
    settle(3);
    chk("bad restore", ref_kind_r, REF_PRESET);
    foreach (srcs[k]) if (k < 2) begin
      wr_cfg(SEL_REF_SOURCE, 16'(SRC_PRESET));
      wr_cfg(SEL_RESTORE, k == 0 ? RESTORE_HIGH : RESTORE_LOW);
      settle(12);
      chk("restored map", {ref_kind_r, ref_value_r},
          exp_ref(SRC_FACTORY, 1'b1, 1'b0, 1'b0));
      chk("restored ptc", ptc_mode_r, 0);
    end
    results();
  end
endmodule // speed_reference_selector_test
`default_nettype wire
